// [hdl/nand_ecc_layout_status.sv]
// Page ECC layout guard, correction result code and busy sequencer
// Contract
// - Four 512-byte data areas are ECC covered
// - Spare bytes 0..3 unprotected; 800h bad mark
// - Spare bytes 4..11 are covered metadata
// - Spare bytes 12..15 hold generated parity
// - Two-bit code: none, 1-7, failed, 8
// - Array read ends within 120 us, busy
// - Program ends within 0.7 ms, busy
// - Erase ends within 5 ms, busy
// - Code cleared on reset, read start
// - Parity writes dropped while ECC enabled
`timescale 1ns/10ps
module nand_ecc_layout_status #(
  parameter logic [19:0] READ_CYC = 20'(nand_ecc_pkg::ARRAY_READ_CYC),
  parameter logic [19:0] PROG_CYC = 20'(nand_ecc_pkg::PAGE_PROGRAM_CYC),
  parameter logic [19:0] ERASE_CYC = 20'(nand_ecc_pkg::BLOCK_ERASE_CYC),
  parameter logic [19:0] RESET_CYC = 20'(nand_ecc_pkg::RESET_CYC)
) (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic ecc_enable_i,
  input nand_ecc_pkg::cmd_s cmd_i,
  input nand_ecc_pkg::corr_s corr_i,
  input nand_ecc_pkg::wr_s host_wr_i,
  output nand_ecc_pkg::wr_s buf_wr_o,
  output nand_ecc_pkg::region_e region_o,
  output logic [1:0] ecc_result_code_o,
  output logic operation_in_progress_flag_o,
  output logic op_done_o
);
  import nand_ecc_pkg::*;

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------

  // Place a byte address of the page buffer in the ECC layout
  function automatic region_e classify(input logic [11:0] addr);
    region_e rg;
    rg = RG_OUTSIDE;
    if (addr <= MAIN_LAST) begin
      rg = RG_MAIN;
    end else if (addr[11:6] == SPARE_TAG) begin
      case (addr[3:2])
        QUAD_UNPROT: begin
          rg = (addr == BAD_MARK_ADDR) ? RG_BAD_MARK : RG_UNPROT;
        end
        QUAD_META_A, QUAD_META_B: begin
          rg = RG_META;
        end
        QUAD_PARITY: begin
          rg = RG_PARITY;
        end
        default: begin
          rg = RG_OUTSIDE;
        end
      endcase
    end
    return rg;
  endfunction

  // Map a count of bit errors onto the two-bit result code
  function automatic logic [1:0] code_of(input logic [4:0] bits);
    logic [1:0] c;
    c = ECC_NONE;
    if (bits == 5'h00) begin
      c = ECC_NONE;
    end else if (bits < ECC_MAX_FIX) begin
      c = ECC_FIXED_LOW;
    end else if (bits == ECC_MAX_FIX) begin
      c = ECC_FIXED_MAX;
    end else begin
      c = ECC_FAILED;
    end
    return c;
  endfunction

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    state_e state;
    logic busy;
    logic done;
    logic [1:0] ecc_code;
    logic [1:0] pend_code;
    wr_s buf_wr;
    region_e region;
  } top_s;

  top_s st_ff;
  top_s nxt_st;
  logic tmr_load;
  logic [TMR_W-1:0] tmr_val;
  logic tmr_done;
  logic accept;
  logic wr_drop;
  region_e wr_region;

  // Start decode: reset aborts anything, others only when idle
  assign accept = cmd_i.valid &&
                  ((st_ff.state == ST_IDLE) || (cmd_i.op == OP_RESET));
  assign wr_region = classify(host_wr_i.addr);
  assign wr_drop = ecc_enable_i && (wr_region == RG_PARITY);

  // Next state of the sequencer, code and write path
  always_comb begin
    nxt_st = st_ff;
    nxt_st.done = 1'b0;
    tmr_load = 1'b0;
    tmr_val = READ_CYC - 20'h00001;
    // Buffer writes pass one cycle late; with ECC on, parity bytes stay generated
    nxt_st.buf_wr = host_wr_i;
    nxt_st.buf_wr.valid = host_wr_i.valid && !wr_drop;
    if (host_wr_i.valid) begin
      nxt_st.region = wr_region;
    end
    // Latch the decoder verdict of the running read
    if ((st_ff.state == ST_READ) && corr_i.valid && ecc_enable_i) begin
      nxt_st.pend_code = code_of(corr_i.err_bits);
    end
    if (accept) begin
      tmr_load = 1'b1;
      nxt_st.busy = 1'b1;
      case (cmd_i.op)
        OP_READ: begin
          nxt_st.state = ST_READ;
          tmr_val = READ_CYC - 20'h00001;
          nxt_st.ecc_code = ECC_NONE;
          nxt_st.pend_code = ECC_NONE;
        end
        OP_PROG: begin
          nxt_st.state = ST_PROG;
          tmr_val = PROG_CYC - 20'h00001;
        end
        OP_ERASE: begin
          nxt_st.state = ST_ERASE;
          tmr_val = ERASE_CYC - 20'h00001;
        end
        default: begin
          nxt_st.state = ST_RESET;
          tmr_val = RESET_CYC - 20'h00001;
          nxt_st.ecc_code = ECC_NONE;
          nxt_st.pend_code = ECC_NONE;
        end
      endcase
    end else if (tmr_done && st_ff.busy) begin
      // Interval over: drop busy and publish a finished read
      nxt_st.busy = 1'b0;
      nxt_st.done = 1'b1;
      nxt_st.state = ST_IDLE;
      if (st_ff.state == ST_READ) begin
        nxt_st.ecc_code = st_ff.pend_code;
      end
    end
  end

  // State register
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      st_ff <= '{state: ST_IDLE, busy: 1'b0, done: 1'b0,
                 ecc_code: ECC_NONE, pend_code: ECC_NONE,
                 buf_wr: WR_RST, region: RG_MAIN};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Interval timer for read, program, erase and reset
  busy_timer u_timer (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .load_i(tmr_load),
    .load_val_i(tmr_val),
    .done_o(tmr_done)
  );

  // Outputs straight from the state register
  assign buf_wr_o = st_ff.buf_wr;
  assign region_o = st_ff.region;
  assign ecc_result_code_o = st_ff.ecc_code;
  assign operation_in_progress_flag_o = st_ff.busy;
  assign op_done_o = st_ff.done;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------

  // Cycles spent busy in the current operation
  logic [TMR_W-1:0] busy_cnt_ff;
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      busy_cnt_ff <= TMR_RST;
    end else if (accept) begin
      busy_cnt_ff <= TMR_RST;
    end else if (st_ff.busy) begin
      busy_cnt_ff <= busy_cnt_ff + 20'h00001;
    end
  end

  a_main_cover: assert property (
    @(posedge ref_clk_i) disable iff (reset_i)
    host_wr_i.valid && (host_wr_i.addr < 12'h800)
    |=> (region_o == RG_MAIN) && buf_wr_o.valid)
    else $error("main area write not classed as covered");

  a_spare_unprot: assert property (
    @(posedge ref_clk_i) disable iff (reset_i)
    host_wr_i.valid && (host_wr_i.addr[11:6] == 6'h20) &&
    (host_wr_i.addr[3:2] == 2'h0)
    |=> region_o == (($past(host_wr_i.addr) == 12'h800) ?
                     RG_BAD_MARK : RG_UNPROT))
    else $error("spare head bytes misclassified");

  a_meta_cover: assert property (
    @(posedge ref_clk_i) disable iff (reset_i)
    host_wr_i.valid && (host_wr_i.addr[11:6] == 6'h20) &&
    (host_wr_i.addr[3:2] inside {2'h1, 2'h2})
    |=> (region_o == RG_META) && buf_wr_o.valid)
    else $error("metadata bytes not classed as covered");

  a_parity_place: assert property (
    @(posedge ref_clk_i) disable iff (reset_i)
    host_wr_i.valid && (host_wr_i.addr[11:6] == 6'h20) &&
    (host_wr_i.addr[3:2] == 2'h3) |=> region_o == RG_PARITY)
    else $error("parity bytes misplaced");

  a_parity_drop: assert property (
    @(posedge ref_clk_i) disable iff (reset_i)
    host_wr_i.valid && (wr_region == RG_PARITY)
    |=> buf_wr_o.valid == !$past(ecc_enable_i))
    else $error("parity write not gated by ECC enable");

  a_code_eight: assert property (
    @(posedge ref_clk_i) disable iff (reset_i)
    (st_ff.state == ST_READ) && corr_i.valid && ecc_enable_i && !accept &&
    (corr_i.err_bits == 5'h08) ##1 (tmr_done && !accept)
    |=> ecc_result_code_o == 2'h3)
    else $error("eight-bit correction not reported as 11");

  a_code_clear: assert property (
    @(posedge ref_clk_i) disable iff (reset_i)
    accept && (cmd_i.op inside {OP_READ, OP_RESET})
    |=> (ecc_result_code_o == 2'h0) && operation_in_progress_flag_o)
    else $error("result code not cleared at start");

  a_code_hold: assert property (
    @(posedge ref_clk_i) disable iff (reset_i)
    operation_in_progress_flag_o && !tmr_done && !accept
    |=> $stable(ecc_result_code_o))
    else $error("result code moved during an operation");

  a_read_time: assert property (
    @(posedge ref_clk_i) disable iff (reset_i)
    (st_ff.state == ST_READ) |-> busy_cnt_ff < READ_CYC)
    else $error("array read busy too long");

  a_prog_time: assert property (
    @(posedge ref_clk_i) disable iff (reset_i)
    (st_ff.state == ST_PROG) |-> operation_in_progress_flag_o &&
    (busy_cnt_ff < 20'(PAGE_PROGRAM_MAX_CYC)))
    else $error("page program busy too long");

  a_erase_time: assert property (
    @(posedge ref_clk_i) disable iff (reset_i)
    (st_ff.state == ST_ERASE) |-> operation_in_progress_flag_o &&
    (busy_cnt_ff < 20'(BLOCK_ERASE_MAX_CYC)))
    else $error("block erase busy too long");

endmodule

// [hdl/nand_ecc_pkg.sv]
// Package with page layout, result codes, timings and carriers
package nand_ecc_pkg;

  // ------------------------------------------------------------
  // Page layout
  // ------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam logic [11:0] MAIN_LAST = 12'h7ff; // Four 200h-byte data areas
  localparam logic [11:0] MAIN_SEG = 12'h200;
  localparam logic [11:0] BAD_MARK_ADDR = 12'h800;
  localparam logic [5:0] SPARE_TAG = 6'h20; // Address bits 11:6 of 800h..83fh
  localparam logic [1:0] QUAD_UNPROT = 2'h0; // Bytes 0..3 of a segment
  localparam logic [1:0] QUAD_META_A = 2'h1; // Bytes 4..7
  localparam logic [1:0] QUAD_META_B = 2'h2; // Bytes 8..11
  localparam logic [1:0] QUAD_PARITY = 2'h3; // Bytes 12..15

  // ------------------------------------------------------------
  // Correction result codes
  // ------------------------------------------------------------
  localparam logic [1:0] ECC_NONE = 2'h0;
  localparam logic [1:0] ECC_FIXED_LOW = 2'h1;
  localparam logic [1:0] ECC_FAILED = 2'h2;
  localparam logic [1:0] ECC_FIXED_MAX = 2'h3;
  localparam logic [4:0] ECC_MAX_FIX = 5'h08; // Largest count still fixed

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int TMR_W = 20;
  localparam int ARRAY_READ_TIME_US = 120; // Longest
  localparam real PAGE_PROGRAM_TIME_MS = 0.4; // Typical, longest 0.7
  localparam real PAGE_PROGRAM_MAX_MS = 0.7;
  localparam int BLOCK_ERASE_TIME_MS = 3; // Typical, longest 5
  localparam int BLOCK_ERASE_MAX_MS = 5;
  localparam int RESET_TIME_US = 500; // Longest
  localparam int ARRAY_READ_CYC = ARRAY_READ_TIME_US * CLK_MHZ;
  localparam int PAGE_PROGRAM_CYC =
    $rtoi(PAGE_PROGRAM_TIME_MS * 1000.0 * CLK_MHZ);
  localparam int PAGE_PROGRAM_MAX_CYC =
    $rtoi(PAGE_PROGRAM_MAX_MS * 1000.0 * CLK_MHZ);
  localparam int BLOCK_ERASE_CYC = BLOCK_ERASE_TIME_MS * 1000 * CLK_MHZ;
  localparam int BLOCK_ERASE_MAX_CYC = BLOCK_ERASE_MAX_MS * 1000 * CLK_MHZ;
  localparam int RESET_CYC = RESET_TIME_US * CLK_MHZ;

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    OP_READ = 2'h0,
    OP_PROG = 2'h1,
    OP_ERASE = 2'h2,
    OP_RESET = 2'h3
  } op_e;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_READ = 3'h1,
    ST_PROG = 3'h3,
    ST_ERASE = 3'h2,
    ST_RESET = 3'h6
  } state_e;

  typedef enum logic [2:0] {
    RG_MAIN = 3'h0,
    RG_UNPROT = 3'h1,
    RG_BAD_MARK = 3'h2,
    RG_META = 3'h3,
    RG_PARITY = 3'h4,
    RG_OUTSIDE = 3'h5
  } region_e;

  typedef struct packed {
    logic valid;
    op_e op;
  } cmd_s;

  typedef struct packed {
    logic valid;
    logic [4:0] err_bits; // Saturating count of bit errors in the page
  } corr_s;

  typedef struct packed {
    logic valid;
    logic [11:0] addr;
    logic [7:0] data;
  } wr_s;

  // Reset values
  localparam logic [TMR_W-1:0] TMR_RST = 20'h00000;
  localparam wr_s WR_RST = '{valid: 1'b0, addr: 12'h000, data: 8'h00};

endpackage

// [hdl/busy_timer.sv]
// Down counter that pulses once when a loaded busy interval runs out
`timescale 1ns/10ps
module busy_timer (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic load_i,
  input wire logic [nand_ecc_pkg::TMR_W-1:0] load_val_i,
  output logic done_o
);
  import nand_ecc_pkg::*;

  typedef struct packed {
    logic [TMR_W-1:0] cnt;
    logic done;
  } tmr_s;

  tmr_s st_ff;
  tmr_s nxt_st;

  // Reload on request, otherwise count down to zero
  always_comb begin
    nxt_st = st_ff;
    nxt_st.done = 1'b0;
    if (load_i) begin
      nxt_st.cnt = load_val_i;
    end else if (st_ff.cnt != TMR_RST) begin
      nxt_st.cnt = st_ff.cnt - 20'h00001;
      nxt_st.done = (st_ff.cnt == 20'h00001);
    end
  end

  // State register
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      st_ff <= '{cnt: TMR_RST, done: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign done_o = st_ff.done;

endmodule

// [dv/host_model.sv]
// Host side model that issues commands and polls the done pulse
`timescale 1ns/10ps
module host_model #(
  parameter int PWR_CYC = 10
) (
  input wire logic ref_clk_i,
  input wire logic done_i,
  output nand_ecc_pkg::cmd_s cmd_o
);
  import nand_ecc_pkg::*;

  initial cmd_o = '0;

  // Stay quiet after power-up before the first command
  task automatic powerup();
    repeat (PWR_CYC) @(posedge ref_clk_i);
    #1;
  endtask

  // Pulse one command, then poll for its end instead of a blind wait
  task automatic issue(input op_e op, input bit wait_done, output int cyc);
    cmd_o = '{valid: 1'b1, op: op};
    @(posedge ref_clk_i);
    #1;
    cmd_o = '0;
    cyc = 0;
    while (wait_done && done_i !== 1'b1 && cyc < 1000) begin
      @(posedge ref_clk_i);
      #1;
      cyc++;
    end
  endtask
endmodule

// [dv/tb.sv]
// Self-checking bench for the page ECC layout and status block
`timescale 1ns/10ps
module tb;
  import nand_ecc_pkg::*;
  localparam int RD_N = 20;
  localparam int PG_N = 30;
  localparam int ER_N = 40;
  localparam int RS_N = 25;
  localparam int LIMIT = 5000;
  logic ref_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic ecc_enable_i = 1'b1;
  cmd_s cmd_i;
  corr_s corr_i = '0;
  wr_s host_wr_i = WR_RST;
  wr_s buf_wr_o;
  region_e region_o;
  logic [1:0] ecc_result_code_o;
  logic operation_in_progress_flag_o;
  logic op_done_o;
  int num_errors = 0;
  int n_checks = 0;
  int cycles = 0;

  nand_ecc_layout_status #(
    .READ_CYC(20'(RD_N)),
    .PROG_CYC(20'(PG_N)),
    .ERASE_CYC(20'(ER_N)),
    .RESET_CYC(20'(RS_N))
  ) i_nand_ecc_layout_status (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .ecc_enable_i(ecc_enable_i),
    .cmd_i(cmd_i),
    .corr_i(corr_i),
    .host_wr_i(host_wr_i),
    .buf_wr_o(buf_wr_o),
    .region_o(region_o),
    .ecc_result_code_o(ecc_result_code_o),
    .operation_in_progress_flag_o(operation_in_progress_flag_o),
    .op_done_o(op_done_o)
  );

  host_model i_host_model (
    .ref_clk_i(ref_clk_i),
    .done_i(op_done_o),
    .cmd_o(cmd_i)
  );

  // Clock at 100 MHz
  initial begin
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  // Cut a hang short
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == LIMIT) begin
      num_errors++;
      $display("[ERR] %0t cycle limit reached", $time);
      tally_and_finish();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                       input string msg);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t %s: got %0h want %0h", $time, msg, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Walk boundaries of data area 0, the main/spare and spare/outside edges and the quads of segments 0 and 1; parity bytes drop only with ECC on
  task automatic t_layout();
    logic [11:0] la [17] = '{12'h000, 12'h1ff, 12'h200, 12'h7ff, 12'h800,
      12'h803, 12'h804, 12'h80b, 12'h80c, 12'h80f, 12'h810, 12'h813,
      12'h814, 12'h81b, 12'h81c, 12'h83f, 12'h840};
    region_e lr [17] = '{RG_MAIN, RG_MAIN, RG_MAIN, RG_MAIN, RG_BAD_MARK,
      RG_UNPROT, RG_META, RG_META, RG_PARITY, RG_PARITY, RG_UNPROT,
      RG_UNPROT, RG_META, RG_META, RG_PARITY, RG_PARITY, RG_OUTSIDE};
    logic v;
    for (int k = 0; k < 17; k++) begin
      host_wr_i = '{valid: 1'b1, addr: la[k], data: 8'(k + 8'h5a)};
      @(posedge ref_clk_i);
      #1;
      v = (lr[k] != RG_PARITY);
      check(32'(region_o), 32'(lr[k]), "region");
      check(32'(buf_wr_o.valid), 32'(v), "write kept");
      if (v) begin
        check(32'(buf_wr_o), 32'(host_wr_i), "write copy");
      end
    end
    ecc_enable_i = 1'b0;
    host_wr_i = '{valid: 1'b1, addr: 12'h83c, data: 8'h3c};
    @(posedge ref_clk_i);
    #1;
    host_wr_i = WR_RST;
    check(32'(buf_wr_o.valid), 32'h1, "parity write ecc off");
    check(32'(region_o), 32'(RG_PARITY), "parity region ecc off");
    ecc_enable_i = 1'b1;
    $display("test layout done");
  endtask

  // One read with a decoder verdict part way through
  task automatic t_read(input logic [4:0] eb, input logic [1:0] code,
                        input int dly);
    int n;
    fork
      i_host_model.issue(OP_READ, 1'b1, n);
      begin
        repeat (dly) @(posedge ref_clk_i);
        #1;
        check(32'(ecc_result_code_o), 32'h0, "code at start");
        corr_i = '{valid: 1'b1, err_bits: eb};
        @(posedge ref_clk_i);
        #1;
        corr_i = '0;
      end
    join
    check(n, RD_N, "read busy length");
    check(32'(operation_in_progress_flag_o), 32'h0, "busy at end");
    check(32'(ecc_result_code_o), 32'(code), "result code");
  endtask

  // Every result code, with count boundaries
  task automatic t_codes();
    logic [4:0] eb [6] = '{5'h00, 5'h01, 5'h07, ECC_MAX_FIX, 5'h09, 5'h1f};
    logic [1:0] cd [6] = '{ECC_NONE, ECC_FIXED_LOW, ECC_FIXED_LOW,
      ECC_FIXED_MAX, ECC_FAILED, ECC_FAILED};
    for (int k = 0; k < 6; k++) begin
      t_read(eb[k], cd[k], 2);
    end
    // Verdict one cycle before the last cycle that still counts
    t_read(ECC_MAX_FIX, ECC_FIXED_MAX, RD_N - 2);
    ecc_enable_i = 1'b0;
    t_read(5'h03, ECC_NONE, 2);
    ecc_enable_i = 1'b1;
    t_read(5'h0c, ECC_FAILED, 2);
    $display("test codes done");
  endtask

  // Program and erase lengths; a read while busy is ignored
  task automatic t_prog_erase();
    int n;
    int m;
    fork
      i_host_model.issue(OP_PROG, 1'b1, n);
      begin
        repeat (5) @(posedge ref_clk_i);
        #1;
        i_host_model.issue(OP_READ, 1'b0, m);
      end
    join
    check(n, PG_N, "program busy length");
    check(32'(ecc_result_code_o), 32'(ECC_FAILED), "code kept");
    i_host_model.issue(OP_ERASE, 1'b1, n);
    check(n, ER_N, "erase busy length");
    $display("test program erase done");
  endtask

  // Reset command aborts a running erase and clears the code
  task automatic t_abort();
    int n;
    int m;
    fork
      i_host_model.issue(OP_ERASE, 1'b1, n);
      begin
        repeat (6) @(posedge ref_clk_i);
        #1;
        i_host_model.issue(OP_RESET, 1'b1, m);
      end
    join
    check(m, RS_N, "reset busy length");
    check(n, RS_N + 6, "aborted erase no done");
    check(32'(ecc_result_code_o), 32'h0, "code after reset");
    $display("test abort done");
  endtask

  // Main sequence
  initial begin
    repeat (8) @(posedge ref_clk_i);
    #1;
    reset_i = 1'b0;
    check(32'(ecc_result_code_o), 32'h0, "code out of reset");
    i_host_model.powerup();
    t_layout();
    t_codes();
    t_prog_erase();
    t_abort();
    tally_and_finish();
  end
endmodule
